// ==== hdl/wdt_cfg.svh ====
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// Host I/O port addresses
`define WDT_IDX_PORT 16'h002E
`define WDT_DATA_PORT 16'h002F

// Key bytes written to the index port
`define WDT_KEY_UNLOCK 8'h87
`define WDT_KEY_LOCK 8'hAA

// Register indexes
`define WDT_REG_LDN 8'h07
`define WDT_REG_ACT 8'h30
`define WDT_REG_UNIT 8'hF5
`define WDT_REG_COUNT 8'hF6
`define WDT_REG_CTRL 8'hF7

// Logical unit number of the watchdog
`define WDT_LDN_WDT 8'h08

// Field positions
`define WDT_ACT_EN_BIT 0
`define WDT_UNIT_MIN_BIT 3
`define WDT_CTRL_MOUSE_BIT 7
`define WDT_CTRL_KBD_BIT 6
`define WDT_CTRL_FORCE_BIT 5
`define WDT_CTRL_STAT_BIT 4

// Reset values and fixed read answers
`define WDT_RST_LDN 8'h00
`define WDT_RST_ACT 8'h00
`define WDT_RST_UNIT 8'h00
`define WDT_RST_COUNT 8'h00
`define WDT_RST_CTRL 8'h00
`define WDT_LOCKED_READ 8'hFF
`define WDT_UNMAPPED_READ 8'h00

// Timing: clock rate in Hz, unit lengths in seconds
`define WDT_CLK_HZ 200000000
`define WDT_SEC_PER_UNIT 1
`define WDT_SEC_PER_MIN 60
`define WDT_SEC_CYCLES (`WDT_CLK_HZ * `WDT_SEC_PER_UNIT)

`endif

// ==== hdl/wdt_pkg.sv ====
package wdt_pkg;

	// Configuration access state, Gray coded along locked-half-open
	typedef enum logic [1:0] {
		WDT_LOCKED = 2'h0,
		WDT_HALF = 2'h1,
		WDT_OPEN = 2'h3
	} wdt_cfg_state_e;

	// One byte of the host I/O bus
	typedef logic [7:0] wdt_byte_t;

endpackage

// ==== hdl/wdt_tick_if.sv ====
`timescale 1ns/1ps

// Link between the countdown logic and the unit time base
interface wdt_tick_if;
	logic restart; // Realign the time base to a fresh unit
	logic unit_min; // High selects minutes, low seconds
	logic tick; // One-cycle pulse per elapsed unit

	modport ctrl(output restart, output unit_min, input tick);
	modport base(input restart, input unit_min, output tick);
endinterface

// ==== hdl/wdt_sync.sv ====
`timescale 1ns/1ps

// Two-flop synchroniser for pins from outside the clock domain
module wdt_sync #(
	parameter int W = 3
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);

	logic [W-1:0] meta_r; // First stage, read only by the second stage

	// Both stages clear to zero so no false activity shows at reset
	always_ff @(posedge clock) begin
		if (rst) begin
			meta_r <= '0;
			q_out <= '0;
		end else begin
			meta_r <= d_in;
			q_out <= meta_r;
		end
	end

endmodule

// ==== hdl/wdt_timebase.sv ====
`timescale 1ns/1ps
`include "wdt_cfg.svh"

// Divides the clock into one-cycle second and minute enables
module wdt_timebase #(
	parameter int unsigned CYC_PER_SEC = `WDT_SEC_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	wdt_tick_if.base tb
);

	logic [27:0] cyc_r; // Cycles within the current second
	logic [5:0] sec_r; // Seconds within the current minute
	logic sec_end; // Last cycle of a second
	logic min_end; // Last cycle of a minute

	assign sec_end = (cyc_r == 28'(CYC_PER_SEC - 1));
	assign min_end = sec_end && (sec_r == 6'(`WDT_SEC_PER_MIN - 1));

	// A restart realigns both counters, so a full unit always elapses
	always_ff @(posedge clock) begin
		if (rst || tb.restart) begin
			cyc_r <= '0;
		end else if (sec_end) begin
			cyc_r <= '0;
		end else begin
			cyc_r <= cyc_r + 28'h0000001;
		end
	end

	// Second counter wraps once a minute
	always_ff @(posedge clock) begin
		if (rst || tb.restart) begin
			sec_r <= '0;
		end else if (min_end) begin
			sec_r <= '0;
		end else if (sec_end) begin
			sec_r <= sec_r + 6'h01;
		end
	end

	// Unit pulse of the selected length
	always_ff @(posedge clock) begin
		if (rst || tb.restart) begin
			tb.tick <= 1'b0;
		end else begin
			tb.tick <= tb.unit_min ? min_end : sec_end;
		end
	end

endmodule

// ==== hdl/wdt_top.sv ====
`timescale 1ns/1ps
`include "wdt_cfg.svh"

module wdt_top #(
	parameter int unsigned CYC_PER_SEC = `WDT_SEC_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [15:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata,
	input wire logic kbd_activity,
	input wire logic mouse_activity,
	input wire logic timeout_route_strap,
	output logic irq11_n,
	output logic sys_reset
);

	// Register index match, used by every register decode
	function automatic logic wdt_hit(
		input wdt_pkg::wdt_byte_t idx,
		input wdt_pkg::wdt_byte_t off
	);
		return idx == off;
	endfunction

	// Configuration access state
	wdt_pkg::wdt_cfg_state_e cfg_r;
	wdt_pkg::wdt_cfg_state_e cfg_nxt;

	// Index and register contents
	wdt_pkg::wdt_byte_t index_r; // Last index written while open
	wdt_pkg::wdt_byte_t ldn_r; // Selected logical unit
	logic active_r; // Watchdog function enabled
	wdt_pkg::wdt_byte_t unit_r; // Unit register, bit 3 selects minutes
	wdt_pkg::wdt_byte_t count_r; // Programmed timeout count
	logic mouse_en_r; // Mouse activity restarts the count
	logic kbd_en_r; // Keyboard activity restarts the count
	logic status_r; // Timeout has happened

	// Running countdown
	wdt_pkg::wdt_byte_t cnt_r;

	// Synchronised pins and edge history
	logic [2:0] pins_s; // {strap, mouse, keyboard} after two flops
	logic kbd_d_r; // Keyboard level one cycle back
	logic mouse_d_r; // Mouse level one cycle back

	// Decoded bus strobes
	logic idx_wr; // Write to the index port
	logic data_wr; // Write to the data port while open
	logic data_rd; // Read of the data port while open
	logic wdt_sel; // Watchdog unit is the selected unit
	logic wr_ldn;
	logic wr_act;
	logic wr_unit;
	logic wr_count;
	logic wr_ctrl;

	// Timer events
	logic kbd_edge;
	logic mouse_edge;
	logic act_restart; // Restart from keyboard or mouse activity
	logic restart; // Any restart of the countdown
	logic force_to; // Forced timeout from control bit 5
	logic expire; // Countdown reached zero this cycle
	logic timeout_evt; // Timeout from any cause
	logic route_reset; // Strap selects the reset output

	// Next read answer, latched only on a read strobe
	wdt_pkg::wdt_byte_t rd_nxt;

	// Carries restart and unit choice out, the unit tick back
	wdt_tick_if tb_if ();

	// Unit time base, realigned on every restart
	wdt_timebase #(
		.CYC_PER_SEC(CYC_PER_SEC)
	) u_timebase (
		.clock(clock),
		.rst(rst),
		.tb(tb_if.base)
	);

	// Pins from outside the clock domain pass two flops first
	wdt_sync #(
		.W(3)
	) u_sync (
		.clock(clock),
		.rst(rst),
		.d_in({timeout_route_strap, mouse_activity, kbd_activity}),
		.q_out(pins_s)
	);

	// Strap is a static board level, yet it still passes the synchroniser
	assign route_reset = pins_s[2];

	// Port decode: index port always listens, data port only when open
	assign idx_wr = io_wr && (io_addr == `WDT_IDX_PORT);
	assign data_wr = io_wr && (io_addr == `WDT_DATA_PORT) &&
		(cfg_r == wdt_pkg::WDT_OPEN);
	assign data_rd = io_rd && (io_addr == `WDT_DATA_PORT) &&
		(cfg_r == wdt_pkg::WDT_OPEN);

	// Watchdog registers answer only once its unit is selected
	assign wdt_sel = (ldn_r == `WDT_LDN_WDT);

	// Register write strobes
	assign wr_ldn = data_wr && wdt_hit(index_r, `WDT_REG_LDN);
	assign wr_act = data_wr && wdt_sel && wdt_hit(index_r, `WDT_REG_ACT);
	assign wr_unit = data_wr && wdt_sel && wdt_hit(index_r, `WDT_REG_UNIT);
	assign wr_count = data_wr && wdt_sel &&
		wdt_hit(index_r, `WDT_REG_COUNT);
	assign wr_ctrl = data_wr && wdt_sel && wdt_hit(index_r, `WDT_REG_CTRL);

	// Next configuration state from index port writes
	always_comb begin
		cfg_nxt = cfg_r;
		if (idx_wr) begin
			case (cfg_r)
				wdt_pkg::WDT_LOCKED: begin
					// First key only arms; one key alone opens nothing
					if (io_wdata == `WDT_KEY_UNLOCK) begin
						cfg_nxt = wdt_pkg::WDT_HALF;
					end
				end
				wdt_pkg::WDT_HALF: begin
					// Keys must be back to back on the index port
					if (io_wdata == `WDT_KEY_UNLOCK) begin
						cfg_nxt = wdt_pkg::WDT_OPEN;
					end else begin
						cfg_nxt = wdt_pkg::WDT_LOCKED;
					end
				end
				wdt_pkg::WDT_OPEN: begin
					if (io_wdata == `WDT_KEY_LOCK) begin
						cfg_nxt = wdt_pkg::WDT_LOCKED;
					end
				end
				default: begin
					cfg_nxt = wdt_pkg::WDT_LOCKED;
				end
			endcase
		end
	end

	// Configuration state register
	always_ff @(posedge clock) begin
		if (rst) begin
			cfg_r <= wdt_pkg::WDT_LOCKED;
		end else begin
			cfg_r <= cfg_nxt;
		end
	end

	// Index latch; the lock key and locked writes never become an index, though 8'h87 written while open does
	// An index left from before a lock is still in place after unlock
	always_ff @(posedge clock) begin
		if (rst) begin
			index_r <= '0;
		end else if (idx_wr && (cfg_r == wdt_pkg::WDT_OPEN) &&
			(io_wdata != `WDT_KEY_LOCK)) begin
			index_r <= io_wdata;
		end
	end

	// Logical unit select
	always_ff @(posedge clock) begin
		if (rst) begin
			ldn_r <= `WDT_RST_LDN;
		end else if (wr_ldn) begin
			ldn_r <= io_wdata;
		end
	end

	// Activation: disabled after reset, bit 0 follows each write
	always_ff @(posedge clock) begin
		if (rst) begin
			active_r <= `WDT_RST_ACT == 8'h01;
		end else if (wr_act) begin
			active_r <= io_wdata[`WDT_ACT_EN_BIT];
		end
	end

	// Unit register kept whole so read-modify-write keeps other bits
	always_ff @(posedge clock) begin
		if (rst) begin
			unit_r <= `WDT_RST_UNIT;
		end else if (wr_unit) begin
			unit_r <= io_wdata;
		end
	end

	// Programmed count, reloaded on keyboard or mouse restart
	always_ff @(posedge clock) begin
		if (rst) begin
			count_r <= `WDT_RST_COUNT;
		end else if (wr_count) begin
			count_r <= io_wdata;
		end
	end

	// Restart enables in the control register
	always_ff @(posedge clock) begin
		if (rst) begin
			// Reset values come from the control register's reset byte
			mouse_en_r <= 1'(`WDT_RST_CTRL >> `WDT_CTRL_MOUSE_BIT);
			kbd_en_r <= 1'(`WDT_RST_CTRL >> `WDT_CTRL_KBD_BIT);
		end else if (wr_ctrl) begin
			mouse_en_r <= io_wdata[`WDT_CTRL_MOUSE_BIT];
			kbd_en_r <= io_wdata[`WDT_CTRL_KBD_BIT];
		end
	end

	// Activity edge history, read from the synchronised levels only
	always_ff @(posedge clock) begin
		if (rst) begin
			kbd_d_r <= 1'b0;
			mouse_d_r <= 1'b0;
		end else begin
			kbd_d_r <= pins_s[0];
			mouse_d_r <= pins_s[1];
		end
	end

	// Rising edges only, so a held key restarts the count once
	assign kbd_edge = pins_s[0] && !kbd_d_r;
	assign mouse_edge = pins_s[1] && !mouse_d_r;

	// Activity restarts only when its enable bit is set
	assign act_restart = (kbd_en_r && kbd_edge) ||
		(mouse_en_r && mouse_edge);
	assign restart = wr_count || act_restart;

	// Force bit is a write strobe, so it never holds a stored one
	assign force_to = wr_ctrl && io_wdata[`WDT_CTRL_FORCE_BIT];

	// Expiry on the tick that takes the count from one to zero
	// A restart on that same tick does not hide it: the timeout wins,
	// so a kick that comes too late is still reported
	assign expire = active_r && tb_if.tick && (cnt_r == 8'h01);
	assign timeout_evt = expire || force_to;

	// The time base realigns on every restart
	assign tb_if.restart = restart;
	assign tb_if.unit_min = unit_r[`WDT_UNIT_MIN_BIT];

	// Countdown: a write loads the new value, activity the programmed one
	always_ff @(posedge clock) begin
		if (rst) begin
			cnt_r <= `WDT_RST_COUNT;
		end else if (wr_count) begin
			cnt_r <= io_wdata;
		end else if (act_restart) begin
			cnt_r <= count_r;
		end else if (active_r && tb_if.tick && (cnt_r != 8'h00)) begin
			// Zero holds the timer stopped
			cnt_r <= cnt_r - 8'h01;
		end
	end

	// Timeout status; a timeout in the restart cycle still sets it
	always_ff @(posedge clock) begin
		if (rst) begin
			status_r <= 1'b0;
		end else if (timeout_evt) begin
			status_r <= 1'b1;
		end else if (restart) begin
			status_r <= 1'b0;
		end
	end

	// Outputs follow status; the strap picks which one shows it
	always_ff @(posedge clock) begin
		if (rst) begin
			irq11_n <= 1'b1;
			sys_reset <= 1'b0;
		end else begin
			irq11_n <= !(status_r && !route_reset);
			sys_reset <= status_r && route_reset;
		end
	end

	// Read answer; unlocked reads return register contents, the write-only force bit reads zero
	always_comb begin
		rd_nxt = `WDT_UNMAPPED_READ;
		if (io_addr == `WDT_IDX_PORT) begin
			if (cfg_r == wdt_pkg::WDT_OPEN) begin
				rd_nxt = index_r;
			end else begin
				rd_nxt = `WDT_LOCKED_READ;
			end
		end else if (io_addr == `WDT_DATA_PORT && !data_rd) begin
			// Locked data port reads like an empty bus
			rd_nxt = `WDT_LOCKED_READ;
		end else if (io_addr != `WDT_DATA_PORT) begin
			rd_nxt = `WDT_UNMAPPED_READ;
		end else if (wdt_hit(index_r, `WDT_REG_LDN)) begin
			// Unit select reads back whichever unit is chosen
			rd_nxt = ldn_r;
		end else if (!wdt_sel) begin
			rd_nxt = `WDT_UNMAPPED_READ;
		end else if (wdt_hit(index_r, `WDT_REG_ACT)) begin
			rd_nxt = {7'h00, active_r};
		end else if (wdt_hit(index_r, `WDT_REG_UNIT)) begin
			rd_nxt = unit_r;
		end else if (wdt_hit(index_r, `WDT_REG_COUNT)) begin
			rd_nxt = count_r;
		end else if (wdt_hit(index_r, `WDT_REG_CTRL)) begin
			// Force bit always reads zero, status shows live
			rd_nxt = {mouse_en_r, kbd_en_r, 1'b0, status_r, 4'h0};
		end
	end

	// Read data register, updated on each read strobe
	always_ff @(posedge clock) begin
		if (rst) begin
			io_rdata <= `WDT_UNMAPPED_READ;
		end else if (io_rd) begin
			io_rdata <= rd_nxt;
		end
	end

endmodule

// ==== verif/wdt_top_monitor.sv ====
`timescale 1ns/1ps

// Port-level checks on the watchdog block
module wdt_monitor (
	input wire logic clock,
	input wire logic rst,
	input wire logic [15:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	input wire logic [7:0] io_rdata,
	input wire logic kbd_activity,
	input wire logic mouse_activity,
	input wire logic timeout_route_strap,
	input wire logic irq11_n,
	input wire logic sys_reset
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	// No write since reset, so configuration access must still be shut
	logic wr_seen_r;

	// Tracks the first write after reset
	always_ff @(posedge clock) begin
		if (rst) begin
			wr_seen_r <= 1'b0;
		end else if (io_wr) begin
			wr_seen_r <= 1'b1;
		end
	end

	// Six idle cycles; long enough to flush any activity edge in flight
	sequence irq_quiet_s;
		(!irq11_n && !io_wr && !kbd_activity && !mouse_activity)[*6];
	endsequence
	sequence sys_quiet_s;
		(sys_reset && !io_wr && !kbd_activity && !mouse_activity)[*6];
	endsequence

	AST_RST_OUT: assert property (disable iff (1'b0) rst |=>
		irq11_n && !sys_reset && io_rdata == 8'h00)
		else $error("outputs not idle after reset");
	AST_IRQ_HOLD: assert property (irq_quiet_s |=> !irq11_n)
		else $error("interrupt released without restart");
	AST_SYS_HOLD: assert property (sys_quiet_s |=> sys_reset)
		else $error("reset request released without restart");
	AST_RDATA_HOLD: assert property (!io_rd |=> $stable(io_rdata))
		else $error("read data changed without a read");
	AST_UNMAPPED: assert property (io_rd && io_addr != 16'h002E &&
		io_addr != 16'h002F |=> io_rdata == 8'h00)
		else $error("unmapped read not zero");
	AST_LOCKED_RD: assert property (!wr_seen_r && io_rd &&
		(io_addr == 16'h002E || io_addr == 16'h002F) |=> io_rdata == 8'hFF)
		else $error("locked read not all ones");
	AST_EXCL: assert property (!(!irq11_n && sys_reset))
		else $error("both timeout routes active");
	AST_STRAP_IRQ: assert property ((!timeout_route_strap)[*4] |->
		!sys_reset)
		else $error("reset request while routed to interrupt");
	AST_STRAP_SYS: assert property ((timeout_route_strap)[*4] |->
		irq11_n)
		else $error("interrupt while routed to reset");
endmodule

bind wdt_top wdt_monitor mon_u (.clock(clock), .rst(rst),
	.io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
	.io_wdata(io_wdata), .io_rdata(io_rdata),
	.kbd_activity(kbd_activity), .mouse_activity(mouse_activity),
	.timeout_route_strap(timeout_route_strap),
	.irq11_n(irq11_n), .sys_reset(sys_reset));

// ==== verif/watchdog_timer_indexed_io_tb_top.sv ====
`timescale 1ns/1ps

module watchdog_timer_indexed_io_tb_top;
	// Short unit keeps minute runs brief: a minute is 600 cycles
	localparam int CPS = 10;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [15:0] io_addr = 16'h0000;
	logic io_wr = 1'b0;
	logic io_rd = 1'b0;
	logic [7:0] io_wdata = 8'h00;
	logic [7:0] io_rdata;
	logic kbd_activity = 1'b0;
	logic mouse_activity = 1'b0;
	logic timeout_route_strap = 1'b0;
	logic irq11_n;
	logic sys_reset;
	int n_fail = 0;
	int n_tests = 0;
	int cyc = 0;
	int k;

	// 200 MHz clock
	always #2.5 clock = ~clock;

	wdt_top #(.CYC_PER_SEC(CPS)) dut_u (.clock(clock), .rst(rst),
		.io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
		.io_wdata(io_wdata), .io_rdata(io_rdata),
		.kbd_activity(kbd_activity), .mouse_activity(mouse_activity),
		.timeout_route_strap(timeout_route_strap),
		.irq11_n(irq11_n), .sys_reset(sys_reset));

	// Hang guard; the whole run needs about 1100 cycles
	always @(posedge clock) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			final_report();
		end
	end

	task final_report;
		if (n_fail == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask

	task idle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// One-cycle strobe, then a gap so strobes never merge
	task wr(input logic [15:0] a, input logic [7:0] d);
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		idle(1);
		io_wr = 1'b0;
		idle(1);
	endtask

	task rd(input logic [15:0] a, input logic [7:0] exp, input string nm);
		io_addr = a;
		io_rd = 1'b1;
		idle(1);
		io_rd = 1'b0;
		chk(nm, exp, io_rdata);
		idle(1);
	endtask

	task wreg(input logic [7:0] idx, input logic [7:0] d);
		wr(16'h002E, idx);
		wr(16'h002F, d);
	endtask

	task rreg(input logic [7:0] idx, input logic [7:0] exp, input string nm);
		wr(16'h002E, idx);
		rd(16'h002F, exp, nm);
	endtask

	// Counts cycles until either timeout output fires, bounded
	task wait_trip(input int lo, input int hi, input string nm);
		int c;
		c = 0;
		while (irq11_n !== 1'b0 && sys_reset !== 1'b1 && c < hi + 2) begin
			idle(1);
			c++;
		end
		n_tests++;
		if (c < lo || c > hi) begin
			n_fail++;
			$display("BAD %s exp %0d..%0d got %0d", nm, lo, hi, c);
		end
	endtask

	// Short activity pulse on keyboard (0) or mouse (1)
	task pulse(input int which);
		if (which == 0) kbd_activity = 1'b1;
		else mouse_activity = 1'b1;
		idle(2);
		kbd_activity = 1'b0;
		mouse_activity = 1'b0;
	endtask

	// Main sequence
	initial begin
		idle(20);
		rst = 1'b0;
		rd(16'h002F, 8'hFF, "locked_data");
		rd(16'h0080, 8'h00, "unmapped");
		wr(16'h002E, 8'h87);
		wr(16'h002E, 8'h30);
		wr(16'h002E, 8'h87);
		rd(16'h002F, 8'hFF, "broken_key");
		wr(16'h002E, 8'h87);
		wreg(8'h07, 8'h08);
		rreg(8'hF5, 8'h00, "unit_rst");
		rreg(8'hF6, 8'h00, "count_rst");
		rreg(8'hF7, 8'h00, "ctrl_rst");
		rreg(8'h30, 8'h00, "act_rst");
		rreg(8'h55, 8'h00, "unknown_idx");
		rd(16'h002E, 8'h55, "index_rd");
		// Activation written while another unit is selected is lost
		wreg(8'h07, 8'h01);
		wreg(8'h30, 8'h01);
		wreg(8'h07, 8'h08);
		rreg(8'h30, 8'h00, "wrong_unit");
		wreg(8'h30, 8'h01);
		rreg(8'h30, 8'h01, "act_on");
		wreg(8'hF6, 8'h03);
		// A rewrite before expiry must push the trip out by a full count
		idle(20);
		wreg(8'hF6, 8'h03);
		wait_trip(3 * CPS - 1, 3 * CPS + 4, "sec_expiry");
		chk("irq_low", 8'h00, {7'h00, irq11_n});
		rreg(8'hF7, 8'h10, "status");
		idle(50);
		chk("irq_held", 8'h00, {7'h00, irq11_n});
		wreg(8'hF6, 8'h00);
		idle(2);
		chk("irq_free", 8'h01, {7'h00, irq11_n});
		idle(100);
		rreg(8'hF7, 8'h00, "stopped");
		// Minute unit, routed to system reset
		timeout_route_strap = 1'b1;
		wreg(8'hF5, 8'h08);
		rreg(8'hF5, 8'h08, "unit_min");
		wreg(8'hF6, 8'h01);
		wait_trip(60 * CPS - 1, 60 * CPS + 4, "min_expiry");
		chk("sys_on", 8'h01, {7'h00, sys_reset});
		idle(20);
		wreg(8'hF6, 8'h00);
		idle(2);
		chk("sys_free", 8'h00, {7'h00, sys_reset});
		wreg(8'hF5, 8'h00);
		// Keyboard then mouse restart the count and clear a timeout
		for (k = 0; k < 2; k++) begin
			wreg(8'hF7, (k == 0) ? 8'h40 : 8'h80);
			wreg(8'hF6, 8'h02);
			idle(12);
			pulse(k);
			idle(12);
			chk("act_restart", 8'h00, {7'h00, sys_reset});
			wait_trip(1, 3 * CPS, "act_expiry");
			pulse(k);
			idle(6);
			chk("act_clear", 8'h00, {7'h00, sys_reset});
		end
		// Disabled timer must not count, yet force still works
		wreg(8'hF7, 8'h00);
		wreg(8'h30, 8'h00);
		wreg(8'hF6, 8'h01);
		idle(30);
		chk("off_idle", 8'h00, {7'h00, sys_reset});
		wreg(8'hF7, 8'h20);
		idle(2);
		chk("forced", 8'h01, {7'h00, sys_reset});
		rreg(8'hF7, 8'h10, "force_self_clr");
		wreg(8'hF6, 8'h00);
		idle(2);
		rreg(8'hF7, 8'h00, "status_clr");
		wr(16'h002E, 8'hAA);
		rd(16'h002F, 8'hFF, "relocked");
		rd(16'h002E, 8'hFF, "locked_idx");
		final_report();
	end
endmodule
